// *** logic/banked_data_memory_access.sv ***
// data-memory address decoder with indirect and program-space access
`timescale 1ns/1ps
module banked_data_memory_access
   import bank_mem_pkg::*;
(
   input  wire logic                   core_clk,
   input  wire logic                   rst,
   input  wire logic                   op_valid,
   input  wire logic [2:0]             op_code,
   input  wire logic [OFS_W-1:0]       op_offset,
   input  wire logic                   op_ptr_sel,
   input  wire logic [DATA_W-1:0]      op_wdata,
   input  wire logic [15:0]            op_ptr_value,
   input  wire logic [PROG_W-1:0]      prog_rdata,
   output logic      [PROG_ADDR_W-1:0] prog_addr_ff,
   output logic                        prog_rd_ff,
   output logic      [DATA_W-1:0]      rd_data_ff,
   output logic                        rd_valid_ff,
   output logic      [DATA_W-1:0]      accum_ff,
   output logic                        busy_ff,
   output logic      [BANK_W-1:0]      bank_select_register_ff,
   output logic      [15:0]            ptr0_ff,
   output logic      [15:0]            ptr1_ff
);
   // ********************
   // decode
   // ********************
   acc_state_e state_ff;
   acc_state_e nxt_state;
   op_e        op;
   logic [DATA_W-1:0] ram_rdata;
   logic       pend_acc_ff;
   logic       pend_zero_ff;
   logic       pend_common_ff;
   logic [DATA_W-1:0] prog_byte;

   assign op = op_e'(op_code);
   // accept new ops only while idle
   wire take = op_valid && (state_ff == ST_IDLE);
   wire [15:0] sel_ptr = op_ptr_sel ? ptr1_ff : ptr0_ff;
   wire is_ind  = (op == OP_IND_RD) || (op == OP_IND_WR);
   wire is_dir  = (op == OP_DIRECT_RD) || (op == OP_DIRECT_WR);
   wire is_rd   = (op == OP_IND_RD) || (op == OP_DIRECT_RD);
   wire is_wr   = (op == OP_IND_WR) || (op == OP_DIRECT_WR);
   // pointer high byte bit 7 selects program space
   wire to_prog = is_ind && sel_ptr[8+PGM_BIT];
   // direct address from bank register, indirect from pointer
   wire [ADDR_W-1:0] daddr = is_dir ? {bank_select_register_ff, op_offset}
                                    : sel_ptr[ADDR_W-1:0];
   wire [BANK_W-1:0] bank = daddr[ADDR_W-1:OFS_W];
   wire [OFS_W-1:0]  ofs  = daddr[OFS_W-1:0];
   // region decode within the bank
   wire in_common  = (ofs >= COMMON_BEG);
   wire in_general = (ofs >= SPECIAL_END) && (ofs < GENERAL_END)
                     && (32'(bank) < GENERAL_BANKS);
   wire ram_hit    = in_common || in_general;
   wire [RAM_AW-1:0] general_idx =
      RAM_AW'(32'(bank) * GENERAL_SIZE + 32'(ofs - SPECIAL_END));
   wire [RAM_AW-1:0] ram_addr = in_common
      ? RAM_AW'(GENERAL_BANKS * GENERAL_SIZE + 32'(ofs - COMMON_BEG)) : general_idx;
   // program writes never reach storage
   wire ram_wr = take && is_wr && !to_prog && ram_hit;
   assign prog_byte = prog_rdata[DATA_W-1:0];

   general_ram u_ram (
      .core_clk   (core_clk),
      .wr_en      (ram_wr),
      .addr       (ram_addr),
      .wr_data    (op_wdata),
      .rd_data_ff (ram_rdata)
   );

   // ********************
   // sequencing
   // ********************
   // next state: program reads take one cycle longer than data reads
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (take && is_rd && to_prog) begin
               nxt_state = ST_PROG_WAIT;
            end else if (take && is_rd) begin
               nxt_state = ST_DATA;
            end
         end
         ST_DATA:      nxt_state = ST_IDLE;
         ST_PROG_WAIT: nxt_state = ST_PROG_DONE;
         ST_PROG_DONE: nxt_state = ST_IDLE;
         default:      nxt_state = ST_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // capture per-access flags
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pend_acc_ff    <= 1'b0;
         pend_zero_ff   <= 1'b0;
         pend_common_ff <= 1'b0;
      end else if (take) begin
         pend_acc_ff    <= (op == OP_IND_RD);
         pend_zero_ff   <= !ram_hit;
         pend_common_ff <= in_common;
      end
   end

   // ********************
   // architectural registers
   // ********************
   // bank select and two pointers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bank_select_register_ff <= BANK_SEL_RST;
         ptr0_ff <= PTR_RST;
         ptr1_ff <= PTR_RST;
      end else if (take && op == OP_SET_BANK) begin
         bank_select_register_ff <= op_wdata[BANK_W-1:0];
      end else if (take && op == OP_SET_PTR) begin
         if (op_ptr_sel) begin
            ptr1_ff <= op_ptr_value;
         end else begin
            ptr0_ff <= op_ptr_value;
         end
      end
   end

   // program-space fetch strobe and address
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prog_rd_ff   <= 1'b0;
         prog_addr_ff <= '0;
      end else begin
         prog_rd_ff <= take && is_rd && to_prog;
         if (take && to_prog) begin
            prog_addr_ff <= sel_ptr[PROG_ADDR_W-1:0];
         end
      end
   end

   // read data, valid and accumulator
   wire data_done = (state_ff == ST_DATA);
   wire prog_done = (state_ff == ST_PROG_DONE);
   wire [DATA_W-1:0] data_val = pend_zero_ff ? ZERO_BYTE : ram_rdata;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rd_data_ff  <= ZERO_BYTE;
         rd_valid_ff <= 1'b0;
         accum_ff    <= ZERO_BYTE;
      end else begin
         rd_valid_ff <= data_done || prog_done;
         if (data_done) begin
            rd_data_ff <= data_val;
            if (pend_acc_ff) accum_ff <= data_val;
         end else if (prog_done) begin
            rd_data_ff <= prog_byte;
            accum_ff   <= prog_byte;
         end else if (take && op == OP_RET_LIT) begin
            accum_ff <= op_wdata;
         end
      end
   end

   // busy while a read is in flight
   always_ff @(posedge core_clk) begin
      if (rst) begin
         busy_ff <= 1'b0;
      end else begin
         busy_ff <= (nxt_state != ST_IDLE);
      end
   end

   // ********************
   // checks
   // ********************
   property p_prog_sel;
      @(posedge core_clk) disable iff (rst)
      (take && op == OP_IND_RD && to_prog) |=> prog_rd_ff;
   endproperty
   a_prog_sel: assert property (p_prog_sel) else $error("program fetch missing");

   property p_prog_acc;
      @(posedge core_clk) disable iff (rst)
      (state_ff == ST_PROG_DONE) |=> (accum_ff == $past(prog_byte));
   endproperty
   a_prog_acc: assert property (p_prog_acc) else $error("accumulator not loaded");

   property p_no_prog_wr;
      @(posedge core_clk) disable iff (rst)
      (op_valid && op == OP_IND_WR && to_prog) |-> !ram_wr;
   endproperty
   a_no_prog_wr: assert property (p_no_prog_wr) else $error("program write reached ram");

   property p_prog_lat;
      @(posedge core_clk) disable iff (rst)
      (take && is_rd && to_prog) |=> !rd_valid_ff ##1 !rd_valid_ff ##1 rd_valid_ff;
   endproperty
   a_prog_lat: assert property (p_prog_lat) else $error("program read latency wrong");

   property p_data_lat;
      @(posedge core_clk) disable iff (rst)
      (take && is_rd && !to_prog) |=> !rd_valid_ff ##1 rd_valid_ff;
   endproperty
   a_data_lat: assert property (p_data_lat) else $error("data read latency wrong");

   property p_unimpl_zero;
      @(posedge core_clk) disable iff (rst)
      (take && is_rd && !to_prog && !ram_hit) |-> ##2 (rd_data_ff == ZERO_BYTE);
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented not zero");

   property p_bank_sel;
      @(posedge core_clk) disable iff (rst)
      (take && op == OP_SET_BANK) |=> (bank_select_register_ff == $past(op_wdata[4:0]));
   endproperty
   a_bank_sel: assert property (p_bank_sel) else $error("bank select not updated");

   property p_retlit;
      @(posedge core_clk) disable iff (rst)
      (take && op == OP_RET_LIT) |=> (accum_ff == $past(op_wdata));
   endproperty
   a_retlit: assert property (p_retlit) else $error("literal not loaded");

   property p_common;
      @(posedge core_clk) disable iff (rst)
      (take && is_dir && op_offset >= COMMON_BEG) |-> ram_hit;
   endproperty
   a_common: assert property (p_common) else $error("common ram not mapped");

   property p_prog_addr;
      @(posedge core_clk) disable iff (rst)
      (take && to_prog) |=> (prog_addr_ff == $past(sel_ptr[PROG_ADDR_W-1:0]));
   endproperty
   a_prog_addr: assert property (p_prog_addr) else $error("program address wrong");

   property p_prog_pulse;
      @(posedge core_clk) disable iff (rst)
      prog_rd_ff |=> !prog_rd_ff;
   endproperty
   a_prog_pulse: assert property (p_prog_pulse) else $error("fetch strobe too long");

   property p_data_no_fetch;
      @(posedge core_clk) disable iff (rst)
      (take && is_rd && !to_prog) |=> !prog_rd_ff;
   endproperty
   a_data_no_fetch: assert property (p_data_no_fetch) else $error("data read fetched");

   property p_prog_wr_no_fetch;
      @(posedge core_clk) disable iff (rst)
      (take && op == OP_IND_WR && to_prog) |=> !prog_rd_ff;
   endproperty
   a_prog_wr_no_fetch: assert property (p_prog_wr_no_fetch) else $error("write fetched");

   property p_prog_busy;
      @(posedge core_clk) disable iff (rst)
      (take && is_rd && to_prog) |=> busy_ff ##1 busy_ff ##1 !busy_ff;
   endproperty
   a_prog_busy: assert property (p_prog_busy) else $error("program busy span wrong");

   property p_data_busy;
      @(posedge core_clk) disable iff (rst)
      (take && is_rd && !to_prog) |=> busy_ff ##1 !busy_ff;
   endproperty
   a_data_busy: assert property (p_data_busy) else $error("data busy span wrong");

   property p_ind_acc;
      @(posedge core_clk) disable iff (rst)
      (data_done && pend_acc_ff) |=> (accum_ff == $past(data_val));
   endproperty
   a_ind_acc: assert property (p_ind_acc) else $error("indirect read not in accumulator");

   property p_dir_acc;
      @(posedge core_clk) disable iff (rst)
      (data_done && !pend_acc_ff) |=> $stable(accum_ff);
   endproperty
   a_dir_acc: assert property (p_dir_acc) else $error("direct read changed accumulator");

   property p_ptr1_set;
      @(posedge core_clk) disable iff (rst)
      (take && op == OP_SET_PTR && op_ptr_sel) |=> (ptr1_ff == $past(op_ptr_value));
   endproperty
   a_ptr1_set: assert property (p_ptr1_set) else $error("pointer one not loaded");

   property p_ptr0_set;
      @(posedge core_clk) disable iff (rst)
      (take && op == OP_SET_PTR && !op_ptr_sel) |=> (ptr0_ff == $past(op_ptr_value));
   endproperty
   a_ptr0_set: assert property (p_ptr0_set) else $error("pointer zero not loaded");

   property p_refuse;
      @(posedge core_clk) disable iff (rst)
      (op_valid && state_ff != ST_IDLE) |=> ($stable(bank_select_register_ff)
         && $stable(ptr0_ff) && $stable(ptr1_ff));
   endproperty
   a_refuse: assert property (p_refuse) else $error("request taken while busy");

   property p_bank_map;
      @(posedge core_clk) disable iff (rst)
      (take && is_dir) |-> (bank == bank_select_register_ff);
   endproperty
   a_bank_map: assert property (p_bank_map) else $error("direct bank not from register");

   c_prog_read: cover property (@(posedge core_clk) prog_done);
   c_data_read: cover property (@(posedge core_clk) data_done && !pend_zero_ff);
   c_zero_read: cover property (@(posedge core_clk) data_done && pend_zero_ff);
   c_retlit:    cover property (@(posedge core_clk) take && op == OP_RET_LIT);
   c_common:    cover property (@(posedge core_clk) data_done && pend_common_ff);
endmodule

// *** inc/bank_mem_pkg.sv ***
// constants and types for the banked data memory access block
package bank_mem_pkg;
   // ********************
   // address layout
   // ********************
   localparam int ADDR_W      = 12;
   localparam int BANK_W      = 5;
   localparam int OFS_W       = 7;
   localparam int NUM_BANKS   = 32;
   localparam int BANK_BYTES  = 128;
   localparam int DATA_W      = 8;
   localparam int PROG_W      = 14;
   localparam int PROG_ADDR_W = 15;
   // per-bank region limits
   localparam logic [6:0] CORE_END   = 7'h0c; // 12 core registers
   localparam logic [6:0] SPECIAL_END = 7'h20; // 20 special registers
   localparam logic [6:0] GENERAL_END = 7'h70; // up to 80 general bytes
   localparam logic [6:0] COMMON_BEG  = 7'h70; // 16 common bytes
   // implemented general-purpose ram banks (fixed package localparam, plain value)
   localparam int GENERAL_BANKS = 4;
   localparam int GENERAL_SIZE  = 80;
   localparam int COMMON_SIZE   = 16;
   localparam int RAM_DEPTH     = GENERAL_BANKS * GENERAL_SIZE + COMMON_SIZE;
   localparam int RAM_AW      = 9;
   localparam int PGM_BIT     = 7; // pointer high byte bit selecting program space
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [4:0] BANK_SEL_RST = 5'h00;
   localparam logic [15:0] PTR_RST  = 16'h0000;

   // ********************
   // operations and states
   // ********************
   typedef enum logic [2:0] {
      OP_NONE, OP_DIRECT_RD, OP_DIRECT_WR, OP_IND_RD, OP_IND_WR, OP_RET_LIT,
      OP_SET_BANK, OP_SET_PTR
   } op_e;
   typedef enum {ST_IDLE, ST_DATA, ST_PROG_WAIT, ST_PROG_DONE} acc_state_e;
endpackage

// *** logic/gpr_ram.sv ***
// single-port byte ram with registered read data
`timescale 1ns/1ps
module general_ram
   import bank_mem_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              wr_en,
   input  wire logic [RAM_AW-1:0] addr,
   input  wire logic [DATA_W-1:0] wr_data,
   output logic      [DATA_W-1:0] rd_data_ff
);
   logic [DATA_W-1:0] mem [RAM_DEPTH];

   // ********************
   // storage
   // ********************
   // write and registered read
   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem[addr] <= wr_data;
      end
      rd_data_ff <= mem[addr];
   end
endmodule

// *** test/prog_rom_model.sv ***
// behavioural program memory standing on the far side of the block
`timescale 1ns/1ps
module prog_rom_model
   import bank_mem_pkg::*;
(
   input  wire logic                   core_clk,
   input  wire logic [PROG_ADDR_W-1:0] prog_addr_ff,
   input  wire logic                   prog_rd_ff,
   output logic      [PROG_W-1:0]      prog_rdata
);
   logic              rd_seen_ff;
   logic [PROG_W-1:0] word;

   // ********************
   // fetch window
   // ********************
   // remembers a fetch so the word stays valid in the following cycle
   always_ff @(posedge core_clk) begin
      rd_seen_ff <= prog_rd_ff;
   end

   // word is a simple function of the address; outside a fetch it is inverted
   assign word       = prog_addr_ff[PROG_W-1:0] ^ 14'h1555;
   assign prog_rdata = (prog_rd_ff | rd_seen_ff) ? word : ~word; // held one cycle past the fetch strobe, then inverted
endmodule

// *** test/banked_data_memory_access_bench.sv ***
// self-checking testbench for the banked data memory access block
`timescale 1ns/1ps
module banked_data_memory_access_bench;
   import bank_mem_pkg::*;
   logic core_clk = 1'b0, rst = 1'b1, op_valid = 1'b0, op_ptr_sel = 1'b0;
   logic [2:0] op_code = 3'h0;
   logic [6:0] op_offset = 7'h00;
   logic [7:0] op_wdata = 8'h00, rd_data_ff, accum_ff;
   logic [15:0] op_ptr_value = 16'h0000, ptr0_ff, ptr1_ff;
   logic [13:0] prog_rdata;
   logic [14:0] prog_addr_ff;
   logic prog_rd_ff, rd_valid_ff, busy_ff;
   logic [4:0] bank_select_register_ff;
   int n_errors = 0, checked = 0;

   // ********************
   // clock, design and far side
   // ********************
   always #12.5 core_clk = ~core_clk;
   banked_data_memory_access uut (.core_clk(core_clk), .rst(rst), .op_valid(op_valid),
      .op_code(op_code), .op_offset(op_offset), .op_ptr_sel(op_ptr_sel),
      .op_wdata(op_wdata), .op_ptr_value(op_ptr_value), .prog_rdata(prog_rdata),
      .prog_addr_ff(prog_addr_ff), .prog_rd_ff(prog_rd_ff), .rd_data_ff(rd_data_ff),
      .rd_valid_ff(rd_valid_ff), .accum_ff(accum_ff), .busy_ff(busy_ff),
      .bank_select_register_ff(bank_select_register_ff), .ptr0_ff(ptr0_ff),
      .ptr1_ff(ptr1_ff));
   prog_rom_model rom (.core_clk(core_clk), .prog_addr_ff(prog_addr_ff),
      .prog_rd_ff(prog_rd_ff), .prog_rdata(prog_rdata));

   // ********************
   // shared tasks
   // ********************
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one request, held for one edge, inputs changed at falling edges
   task automatic issue(input logic [2:0] code, input logic [6:0] ofs, input logic sel,
                        input logic [7:0] wd, input logic [15:0] pv);
      @(negedge core_clk);
      op_valid = 1'b1;
      op_code = code;
      op_offset = ofs;
      op_ptr_sel = sel;
      op_wdata = wd;
      op_ptr_value = pv;
      @(negedge core_clk);
      op_valid = 1'b0;
   endtask

   // read request, then count cycles to the result and compare it
   task automatic rd(input logic [2:0] code, input logic [6:0] ofs, input logic sel,
                     input logic [7:0] exp, input int lat);
      int n;
      // counts edges from the taking edge to the edge that samples valid
      n = 1;
      issue(code, ofs, sel, 8'h00, 16'h0000);
      chk("busy during read", 16'h0001, {15'h0000, busy_ff});
      chk("prog strobe", (lat == 3) ? 16'h0001 : 16'h0000, {15'h0000, prog_rd_ff});
      do begin
         @(negedge core_clk);
         n++;
      end while (rd_valid_ff !== 1'b1 && n < 10);
      chk("read latency", lat[15:0], n[15:0]);
      chk("read data", {8'h00, exp}, {8'h00, rd_data_ff});
      chk("busy after read", 16'h0000, {15'h0000, busy_ff});
   endtask

   task automatic end_sim;
      if (n_errors == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ********************
   // scenarios
   // ********************
   task automatic t_reset;
      chk("bank after reset", 16'h0000, {11'h000, bank_select_register_ff});
      chk("ptr0 after reset", 16'h0000, ptr0_ff);
      chk("accum after reset", 16'h0000, {8'h00, accum_ff});
   endtask

   task automatic t_banks;
      issue(OP_SET_BANK, 7'h00, 1'b0, 8'h02, 16'h0000);
      chk("bank reg", 16'h0002, {11'h000, bank_select_register_ff});
      issue(OP_DIRECT_WR, 7'h30, 1'b0, 8'ha5, 16'h0000);
      issue(OP_SET_BANK, 7'h00, 1'b0, 8'h03, 16'h0000);
      issue(OP_DIRECT_WR, 7'h30, 1'b0, 8'h5a, 16'h0000);
      rd(OP_DIRECT_RD, 7'h30, 1'b0, 8'h5a, 2);
      issue(OP_SET_BANK, 7'h00, 1'b0, 8'h02, 16'h0000);
      rd(OP_DIRECT_RD, 7'h30, 1'b0, 8'ha5, 2);
   endtask

   task automatic t_unimpl;
      issue(OP_DIRECT_WR, 7'h05, 1'b0, 8'hff, 16'h0000);
      rd(OP_DIRECT_RD, 7'h05, 1'b0, 8'h00, 2);
      issue(OP_SET_BANK, 7'h00, 1'b0, 8'h14, 16'h0000);
      issue(OP_DIRECT_WR, 7'h30, 1'b0, 8'h66, 16'h0000);
      rd(OP_DIRECT_RD, 7'h30, 1'b0, 8'h00, 2);
   endtask

   task automatic t_common;
      issue(OP_SET_BANK, 7'h00, 1'b0, 8'h00, 16'h0000);
      issue(OP_DIRECT_WR, 7'h75, 1'b0, 8'h3c, 16'h0000);
      issue(OP_SET_BANK, 7'h00, 1'b0, 8'h1f, 16'h0000);
      rd(OP_DIRECT_RD, 7'h75, 1'b0, 8'h3c, 2);
   endtask

   task automatic t_indirect;
      issue(OP_SET_PTR, 7'h00, 1'b1, 8'h00, 16'h0130);
      chk("ptr1", 16'h0130, ptr1_ff);
      rd(OP_IND_RD, 7'h00, 1'b1, 8'ha5, 2);
      chk("accum indirect", 16'h00a5, {8'h00, accum_ff});
      issue(OP_SET_PTR, 7'h00, 1'b0, 8'h00, 16'h01b0);
      issue(OP_IND_WR, 7'h00, 1'b0, 8'h77, 16'h0000);
      issue(OP_SET_BANK, 7'h00, 1'b0, 8'h03, 16'h0000);
      rd(OP_DIRECT_RD, 7'h30, 1'b0, 8'h77, 2);
   endtask

   task automatic t_program;
      issue(OP_SET_PTR, 7'h00, 1'b0, 8'h00, 16'h8123);
      rd(OP_IND_RD, 7'h00, 1'b0, 8'h23 ^ 8'h55, 3);
      chk("prog addr", 16'h0123, {1'b0, prog_addr_ff});
      chk("accum program", {8'h00, 8'h23 ^ 8'h55}, {8'h00, accum_ff});
      issue(OP_SET_PTR, 7'h00, 1'b0, 8'h00, 16'h8130);
      issue(OP_IND_WR, 7'h00, 1'b0, 8'hee, 16'h0000);
      issue(OP_SET_BANK, 7'h00, 1'b0, 8'h02, 16'h0000);
      rd(OP_DIRECT_RD, 7'h30, 1'b0, 8'ha5, 2);
   endtask

   task automatic t_literal;
      issue(OP_RET_LIT, 7'h00, 1'b0, 8'hc3, 16'h0000);
      chk("accum literal", 16'h00c3, {8'h00, accum_ff});
   endtask

   // a request raised while a read is in flight is ignored silently
   task automatic t_refuse;
      @(negedge core_clk);
      op_valid = 1'b1;
      op_code = OP_DIRECT_RD;
      op_offset = 7'h75;
      op_wdata = 8'h00;
      @(negedge core_clk);
      op_code = OP_SET_BANK;
      op_wdata = 8'h05;
      @(negedge core_clk);
      op_valid = 1'b0;
      chk("read while busy", 16'h003c, {8'h00, rd_data_ff});
      chk("bank after refusal", 16'h0002, {11'h000, bank_select_register_ff});
   endtask

   // ********************
   // main sequence and watchdog
   // ********************
   initial begin
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      t_reset();
      t_banks();
      t_unimpl();
      t_common();
      t_indirect();
      t_program();
      t_literal();
      t_refuse();
      end_sim();
   end

   initial begin
      #(25 * 2000);
      n_errors++;
      end_sim();
   end
endmodule
